//--- include/uart_link_pkg.sv
// Shared constants for the flow-controlled serial link: frame settings,
// baud divisors and event codes.
// Assumes a 40 MHz system clock on both ends.
package uart_link_pkg;

  // ****************************************
  // Clock and baud
  // ****************************************
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned BAUD_MIN = 1200;
  localparam int unsigned BAUD_DEFAULT = 115200;
  localparam int unsigned BAUD_MAX = 921600;
  // Oversampling by 16 keeps divisor error within budget across the range
  localparam int unsigned OVERSAMPLE = 16;
  localparam int unsigned DIV_W = 16;
  localparam logic [DIV_W-1:0] DIV_DEFAULT = DIV_W'(CLK_HZ / (OVERSAMPLE * BAUD_DEFAULT));
  localparam logic [DIV_W-1:0] DIV_MIN_RATE = DIV_W'(CLK_HZ / (OVERSAMPLE * BAUD_MIN));
  localparam logic [DIV_W-1:0] DIV_MAX_RATE = DIV_W'(CLK_HZ / (OVERSAMPLE * BAUD_MAX));
  localparam logic [DIV_W-1:0] DIV_ONE = 16'h0001;

  // Ticks per bit, half bit and one-and-a-half stop
  localparam logic [4:0] TICKS_BIT = 5'h10;
  localparam logic [4:0] TICKS_HALF = 5'h08;
  localparam logic [4:0] TICKS_STOP15 = 5'h18;
  localparam logic [4:0] TICK_ONE = 5'h01;
  // Two stop bits need 32 ticks, one more bit than the 5-bit counts hold
  localparam logic [5:0] TICKS_STOP2 = 6'h20;

  // ****************************************
  // Frame format
  // ****************************************
  localparam int unsigned DATA_W = 8;
  typedef enum logic [1:0] {LEN5, LEN6, LEN7, LEN8} len_t;
  typedef enum logic [1:0] {PAR_NONE, PAR_ODD, PAR_EVEN} par_t;
  typedef enum logic [1:0] {STOP1, STOP15, STOP2} stop_t;
  localparam logic [3:0] BASE_BITS = 4'h5;

  // ****************************************
  // Event codes, one per interrupt type
  // ****************************************
  localparam int unsigned NUM_EVT = 10;
  localparam int unsigned EV_RX_DONE = 0;
  localparam int unsigned EV_TX_DONE = 1;
  localparam int unsigned EV_TX_EMPTY = 2;
  localparam int unsigned EV_PARITY = 3;
  localparam int unsigned EV_FRAMING = 4;
  localparam int unsigned EV_OVERRUN = 5;
  localparam int unsigned EV_BREAK = 6;
  localparam int unsigned EV_CTS_CHG = 7;
  localparam int unsigned EV_RX_START = 8;
  localparam int unsigned EV_RTS_DROP = 9;

  // Number of data bits for a length code
  function automatic logic [3:0] dataBits(input len_t len);
    return BASE_BITS + 4'(len);
  endfunction : dataBits

endpackage : uart_link_pkg

//--- include/uart_link_if.sv
// Wires joining the module end and the host end of the serial link.
// Assumes both ends share sys_clk; lines idle high, handshakes active low.
`timescale 1ns/1ps
interface uart_link_if;
  logic devTx;
  logic hostTx;
  logic devRtsN;
  logic hostRtsN;

  modport device (output devTx, input hostTx, output devRtsN, input hostRtsN);
  modport host (input devTx, output hostTx, input devRtsN, output hostRtsN);
endinterface : uart_link_if

//--- logic/uart_port_engine.sv
// Serial port engine: one transmitter and one receiver with optional
// active-low flow control, used by both ends of the link.
// Assumes lines are synchronous to sys_clk and both ends share frame settings.
// Behaviour
// RL1: One channel, transmit and receive simultaneously
// RL2: Deserialize receive line, serialize written words
// RL3: Data only on crossed transmit/receive lines
// RL4: Ten distinct event types signalled to CPU
// RL5: Active-low handshakes; ignored when flow off
// RL6: Sender pauses while partner request deasserted
// RL7: Baud selectable 1200 to 921600, default 115200
// RL8: Five to eight bits, parity, stop choices
`timescale 1ns/1ps
module uart_port_engine (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic [uart_link_pkg::DIV_W-1:0] baudDiv,
  input wire uart_link_pkg::len_t charLen,
  input wire uart_link_pkg::par_t parity,
  input wire uart_link_pkg::stop_t stopBits,
  input wire logic flowEn,
  input wire logic [uart_link_pkg::DATA_W-1:0] txData,
  input wire logic txValid,
  output logic txReady,
  output logic [uart_link_pkg::DATA_W-1:0] rxData,
  output logic rxValid,
  input wire logic rxAck,
  output logic [uart_link_pkg::NUM_EVT-1:0] events,
  output logic txLine,
  input wire logic rxLine,
  output logic rtsN,
  input wire logic ctsN
);

  typedef enum logic [2:0] {IDLE, START, DATA, PAR, STOP} st_t;

  // ****************************************
  // Baud tick
  // ****************************************
  logic [uart_link_pkg::DIV_W-1:0] divCnt_ff, nxt_divCnt;
  logic tick;
  always_comb begin
    tick = (divCnt_ff <= uart_link_pkg::DIV_ONE);
    nxt_divCnt = tick ? baudDiv : divCnt_ff - uart_link_pkg::DIV_ONE; // see RL7
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      divCnt_ff <= uart_link_pkg::DIV_DEFAULT;
    end else if (clkEn) begin
      divCnt_ff <= nxt_divCnt;
    end
  end

  function automatic logic [5:0] stopTicks(input uart_link_pkg::stop_t s);
    unique case (s)
      uart_link_pkg::STOP15: return 6'(uart_link_pkg::TICKS_STOP15);
      uart_link_pkg::STOP2: return uart_link_pkg::TICKS_STOP2;
      default: return 6'(uart_link_pkg::TICKS_BIT);
    endcase
  endfunction : stopTicks

  // ****************************************
  // Transmitter
  // ****************************************
  st_t txSt_ff, nxt_txSt;
  logic [uart_link_pkg::DATA_W-1:0] txSh_ff, nxt_txSh;
  logic [5:0] txTk_ff, nxt_txTk;
  logic [3:0] txBit_ff, nxt_txBit;
  logic txPar_ff, nxt_txPar;
  logic txLine_ff, nxt_txLine;
  logic txDone, ctsOk;
  always_comb begin
    ctsOk = !flowEn || !ctsN; // see RL5 see RL6
    nxt_txSt = txSt_ff;
    nxt_txSh = txSh_ff;
    nxt_txTk = txTk_ff;
    nxt_txBit = txBit_ff;
    nxt_txPar = txPar_ff;
    nxt_txLine = txLine_ff;
    txDone = 1'b0;
    unique case (txSt_ff)
      IDLE: begin
        nxt_txLine = 1'b1;
        if (txValid && ctsOk) begin
          nxt_txSh = txData; // see RL2
          nxt_txPar = (parity == uart_link_pkg::PAR_ODD);
          nxt_txSt = START;
          nxt_txTk = 6'(uart_link_pkg::TICKS_BIT);
          nxt_txLine = 1'b0;
        end
      end
      default: if (tick) begin
        nxt_txTk = txTk_ff - 6'(uart_link_pkg::TICK_ONE);
        if (txTk_ff == 6'(uart_link_pkg::TICK_ONE)) begin
          nxt_txTk = 6'(uart_link_pkg::TICKS_BIT);
          unique case (txSt_ff)
            START: begin
              nxt_txSt = DATA;
              nxt_txBit = '0;
              nxt_txLine = txSh_ff[0];
              nxt_txPar = txPar_ff ^ txSh_ff[0];
              nxt_txSh = txSh_ff >> 1;
            end
            DATA: begin
              nxt_txBit = txBit_ff + 4'h1;
              if (txBit_ff + 4'h1 == uart_link_pkg::dataBits(charLen)) begin // see RL8
                if (parity == uart_link_pkg::PAR_NONE) begin
                  nxt_txSt = STOP;
                  nxt_txLine = 1'b1;
                  nxt_txTk = 6'(stopTicks(stopBits));
                end else begin
                  nxt_txSt = PAR;
                  nxt_txLine = txPar_ff;
                end
              end else begin
                nxt_txLine = txSh_ff[0];
                nxt_txPar = txPar_ff ^ txSh_ff[0];
                nxt_txSh = txSh_ff >> 1;
              end
            end
            PAR: begin
              nxt_txSt = STOP;
              nxt_txLine = 1'b1;
              nxt_txTk = 6'(stopTicks(stopBits));
            end
            default: begin
              nxt_txSt = IDLE;
              txDone = 1'b1;
            end
          endcase
        end
      end
    endcase
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      txSt_ff <= IDLE;
      txSh_ff <= '0;
      txTk_ff <= '0;
      txBit_ff <= '0;
      txPar_ff <= 1'b0;
      txLine_ff <= 1'b1;
    end else if (clkEn) begin
      txSt_ff <= nxt_txSt;
      txSh_ff <= nxt_txSh;
      txTk_ff <= nxt_txTk;
      txBit_ff <= nxt_txBit;
      txPar_ff <= nxt_txPar;
      txLine_ff <= nxt_txLine;
    end
  end
  assign txReady = (txSt_ff == IDLE) && ctsOk && clkEn;
  assign txLine = txLine_ff; // see RL3

  // ****************************************
  // Receiver, runs alongside the transmitter
  // ****************************************
  st_t rxSt_ff, nxt_rxSt; // see RL1
  logic [uart_link_pkg::DATA_W-1:0] rxSh_ff, nxt_rxSh, rxData_ff, nxt_rxData;
  logic [4:0] rxTk_ff, nxt_rxTk;
  logic [3:0] rxBit_ff, nxt_rxBit;
  logic rxPar_ff, nxt_rxPar, rxValid_ff, nxt_rxValid, rxLast_ff, ctsLast_ff;
  logic [uart_link_pkg::NUM_EVT-1:0] ev;
  always_comb begin
    nxt_rxSt = rxSt_ff;
    nxt_rxSh = rxSh_ff;
    nxt_rxData = rxData_ff;
    nxt_rxTk = rxTk_ff;
    nxt_rxBit = rxBit_ff;
    nxt_rxPar = rxPar_ff;
    nxt_rxValid = rxValid_ff && !rxAck;
    ev = '0;
    ev[uart_link_pkg::EV_TX_DONE] = txDone;
    ev[uart_link_pkg::EV_TX_EMPTY] = txDone && !txValid;
    ev[uart_link_pkg::EV_CTS_CHG] = flowEn && (ctsN != ctsLast_ff);
    unique case (rxSt_ff)
      IDLE: if (rxLast_ff && !rxLine) begin
        nxt_rxSt = START;
        nxt_rxTk = uart_link_pkg::TICKS_HALF;
        ev[uart_link_pkg::EV_RX_START] = 1'b1;
      end
      default: if (tick) begin
        nxt_rxTk = rxTk_ff - uart_link_pkg::TICK_ONE;
        if (rxTk_ff == uart_link_pkg::TICK_ONE) begin
          nxt_rxTk = uart_link_pkg::TICKS_BIT;
          unique case (rxSt_ff)
            START: begin
              nxt_rxSt = rxLine ? IDLE : DATA; // Glitch rejected at mid-bit
              nxt_rxBit = '0;
              nxt_rxSh = '0;
              nxt_rxPar = (parity == uart_link_pkg::PAR_ODD);
            end
            DATA: begin
              nxt_rxSh = rxSh_ff | (uart_link_pkg::DATA_W'(rxLine) << rxBit_ff); // see RL2
              nxt_rxPar = rxPar_ff ^ rxLine;
              nxt_rxBit = rxBit_ff + 4'h1;
              if (rxBit_ff + 4'h1 == uart_link_pkg::dataBits(charLen)) begin // see RL8
                nxt_rxSt = (parity == uart_link_pkg::PAR_NONE) ? STOP : PAR;
              end
            end
            PAR: begin
              nxt_rxSt = STOP;
              ev[uart_link_pkg::EV_PARITY] = (rxLine != rxPar_ff);
            end
            default: begin
              // Only the first stop bit is checked; extra stop time is idle
              nxt_rxSt = IDLE;
              ev[uart_link_pkg::EV_FRAMING] = !rxLine;
              ev[uart_link_pkg::EV_BREAK] = !rxLine && (rxSh_ff == '0);
              ev[uart_link_pkg::EV_RX_DONE] = 1'b1;
              ev[uart_link_pkg::EV_OVERRUN] = rxValid_ff && !rxAck;
              nxt_rxData = rxSh_ff;
              nxt_rxValid = 1'b1; // New word wins over the acknowledge
            end
          endcase
        end
      end
    endcase
    // Held buffer blocks the partner; dropping it is reported
    ev[uart_link_pkg::EV_RTS_DROP] = flowEn && nxt_rxValid && !rxValid_ff; // see RL4
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxSt_ff <= IDLE;
      rxSh_ff <= '0;
      rxData_ff <= '0;
      rxTk_ff <= '0;
      rxBit_ff <= '0;
      rxPar_ff <= 1'b0;
      rxValid_ff <= 1'b0;
      rxLast_ff <= 1'b1;
      // Partner request idles low (ready), so no false change after reset
      ctsLast_ff <= 1'b0;
      events <= '0;
    end else if (clkEn) begin
      rxSt_ff <= nxt_rxSt;
      rxSh_ff <= nxt_rxSh;
      rxData_ff <= nxt_rxData;
      rxTk_ff <= nxt_rxTk;
      rxBit_ff <= nxt_rxBit;
      rxPar_ff <= nxt_rxPar;
      rxValid_ff <= nxt_rxValid;
      rxLast_ff <= rxLine;
      ctsLast_ff <= ctsN;
      events <= ev; // see RL4
    end
  end
  assign rxData = rxData_ff;
  assign rxValid = rxValid_ff;
  // Request-to-send asserted low while the receive word is free, and always when flow control is off
  assign rtsN = flowEn ? rxValid_ff : 1'b0; // see RL5 see RL6

endmodule : uart_port_engine

//--- logic/uart_host_end.sv
// Host end of the serial link: a user-side word port driving the link.
// Assumes uart_port_engine and the link interface are compiled first.
`timescale 1ns/1ps
module uart_host_end (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic [uart_link_pkg::DIV_W-1:0] baudDiv,
  input wire uart_link_pkg::len_t charLen,
  input wire uart_link_pkg::par_t parity,
  input wire uart_link_pkg::stop_t stopBits,
  input wire logic flowEn,
  input wire logic [uart_link_pkg::DATA_W-1:0] txData,
  input wire logic txValid,
  output logic txReady,
  output logic [uart_link_pkg::DATA_W-1:0] rxData,
  output logic rxValid,
  input wire logic rxAck,
  output logic [uart_link_pkg::NUM_EVT-1:0] events,
  uart_link_if.host link
);
  // Host honours the module's request line before each character: see RL6
  uart_port_engine engine (
    .sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn), .baudDiv(baudDiv),
    .charLen(charLen), .parity(parity), .stopBits(stopBits), .flowEn(flowEn),
    .txData(txData), .txValid(txValid), .txReady(txReady), .rxData(rxData),
    .rxValid(rxValid), .rxAck(rxAck), .events(events),
    .txLine(link.hostTx), .rxLine(link.devTx), .rtsN(link.hostRtsN), .ctsN(link.devRtsN)
  ); // see RL3
endmodule : uart_host_end

//--- logic/uart_device_end.sv
// Module (device) end of the serial link: CPU word port to link pins.
// Assumes uart_port_engine and the link interface are compiled first.
`timescale 1ns/1ps
module uart_device_end (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic [uart_link_pkg::DIV_W-1:0] baudDiv,
  input wire uart_link_pkg::len_t charLen,
  input wire uart_link_pkg::par_t parity,
  input wire uart_link_pkg::stop_t stopBits,
  input wire logic flowEn,
  input wire logic [uart_link_pkg::DATA_W-1:0] txData,
  input wire logic txValid,
  output logic txReady,
  output logic [uart_link_pkg::DATA_W-1:0] rxData,
  output logic rxValid,
  input wire logic rxAck,
  output logic [uart_link_pkg::NUM_EVT-1:0] events,
  uart_link_if.device link
);
  uart_port_engine engine (
    .sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn), .baudDiv(baudDiv),
    .charLen(charLen), .parity(parity), .stopBits(stopBits), .flowEn(flowEn),
    .txData(txData), .txValid(txValid), .txReady(txReady), .rxData(rxData),
    .rxValid(rxValid), .rxAck(rxAck), .events(events),
    .txLine(link.devTx), .rxLine(link.hostTx), .rtsN(link.devRtsN), .ctsN(link.hostRtsN)
  ); // see RL3
endmodule : uart_device_end

//--- tb/uart_link_props.sv
// Checker for the wires joining the two ends of the serial link.
// Assumes baudDiv of 1 or 2, so one bit lasts at least 16 sys_clk cycles.
`timescale 1ns/1ps
module uart_link_props (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic devTx,
  input wire logic hostTx,
  input wire logic devRtsN,
  input wire logic hostRtsN
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // ****************************************
  // Wire properties
  // ****************************************
  property p_devStart; $fell(devTx) |-> ##15 !devTx; endproperty
  property p_hostStart; $fell(hostTx) |-> ##15 !hostTx; endproperty
  property p_devBit; $changed(devTx) |=> $stable(devTx) [*8]; endproperty
  property p_hostBit; $changed(hostTx) |=> $stable(hostTx) [*8]; endproperty
  // A frame may only start after the partner showed ready
  property p_devFlow; $fell(devTx) |-> !$past(hostRtsN); endproperty
  property p_hostFlow; $fell(hostTx) |-> !$past(devRtsN); endproperty
  // Ready drops only once a stop bit has been heard
  property p_devRts; $rose(devRtsN) |-> $past(hostTx) && $past(hostTx, 4); endproperty
  property p_hostRts; $rose(hostRtsN) |-> $past(devTx) && $past(devTx, 4); endproperty
  a_devStart: assert property (p_devStart) else $error("device start bit too short");
  a_hostStart: assert property (p_hostStart) else $error("host start bit too short");
  a_devBit: assert property (p_devBit) else $error("device bit too short");
  a_hostBit: assert property (p_hostBit) else $error("host bit too short");
  a_devFlow: assert property (p_devFlow) else $error("device sent while held");
  a_hostFlow: assert property (p_hostFlow) else $error("host sent while held");
  a_devRts: assert property (p_devRts) else $error("device ready drop early");
  a_hostRts: assert property (p_hostRts) else $error("host ready drop early");
  c_devFrame: cover property ($fell(devTx));
  c_hostFrame: cover property ($fell(hostTx));
  c_devHold: cover property ($rose(devRtsN));
endmodule : uart_link_props

//--- tb/test_module_uart_with_flow_control.sv
// Testbench: device end and host end joined by the link interface.
// Assumes the package and interface are compiled first; one 40 MHz clock.
`timescale 1ns/1ps
module test_module_uart_with_flow_control;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clkEn = 1'b1;
  logic [15:0] baudDiv = uart_link_pkg::DIV_ONE;
  uart_link_pkg::len_t charLen = uart_link_pkg::LEN8;
  uart_link_pkg::par_t par [2] = '{uart_link_pkg::PAR_NONE, uart_link_pkg::PAR_NONE};
  uart_link_pkg::stop_t stopBits = uart_link_pkg::STOP1;
  logic flowEn = 1'b1;
  // Index 0 is the device end, 1 the host end
  logic [7:0] txD [2] = '{8'h00, 8'h00};
  logic txV [2] = '{1'b0, 1'b0};
  logic rxAck [2] = '{1'b0, 1'b0};
  logic txR [2];
  logic rxV [2];
  logic [7:0] rxD [2];
  logic [9:0] ev [2];
  logic [9:0] seen [2];
  logic clrSeen = 1'b1;
  logic [7:0] d;
  int n_errors = 0;
  int checked = 0;
  int cyc = 0;

  uart_link_if link ();
  uart_device_end uart_device_end_i (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn),
    .baudDiv(baudDiv), .charLen(charLen), .parity(par[0]), .stopBits(stopBits),
    .flowEn(flowEn), .txData(txD[0]), .txValid(txV[0]), .txReady(txR[0]), .rxData(rxD[0]),
    .rxValid(rxV[0]), .rxAck(rxAck[0]), .events(ev[0]), .link(link));
  uart_host_end uart_host_end_i (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn),
    .baudDiv(baudDiv), .charLen(charLen), .parity(par[1]), .stopBits(stopBits),
    .flowEn(flowEn), .txData(txD[1]), .txValid(txV[1]), .txReady(txR[1]), .rxData(rxD[1]),
    .rxValid(rxV[1]), .rxAck(rxAck[1]), .events(ev[1]), .link(link));
  uart_link_props uart_link_props_i (.sys_clk(sys_clk), .rst_n(rst_n), .devTx(link.devTx),
    .hostTx(link.hostTx), .devRtsN(link.devRtsN), .hostRtsN(link.hostRtsN));

  always #12.5 sys_clk = ~sys_clk;

  // Events are one-cycle pulses, so keep a sticky copy per end
  always @(posedge sys_clk) begin
    seen[0] <= clrSeen ? 10'h000 : (seen[0] | ev[0]);
    seen[1] <= clrSeen ? 10'h000 : (seen[1] | ev[1]);
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      end_sim();
    end
  end

  task chk(input logic [9:0] got, input logic [9:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task step(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask : step

  // Request held until the edge where ready is sampled high
  task send(input int e, input logic [7:0] v);
    int k;
    k = 0;
    // Let an edge pass so back-to-back calls never lower and raise txValid at once
    step(1);
    txD[e] = v;
    txV[e] = 1'b1;
    while (txR[e] !== 1'b1 && k < 4000) begin
      step(1);
      k++;
    end
    step(1);
    txV[e] = 1'b0;
  endtask : send

  task recv(input int e, input logic [7:0] exp);
    int k;
    k = 0;
    while (rxV[e] !== 1'b1 && k < 4000) begin
      step(1);
      k++;
    end
    chk(rxD[e], exp);
    rxAck[e] = 1'b1;
    step(1);
    rxAck[e] = 1'b0;
  endtask : recv

  // Sticky event copies are cleared by their own process only
  task clear;
    clrSeen = 1'b1;
    step(1);
    clrSeen = 1'b0;
  endtask : clear

  task end_sim;
    $display("errors %0d of %0d checks", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim

  initial begin
    step(2);
    rst_n = 1'b1;
    chk(link.devTx, 1'b1);
    chk(link.hostTx, 1'b1);
    // Every frame format, both directions at once
    for (int l = 0; l < 4; l++)
      for (int p = 0; p < 3; p++)
        for (int s = 0; s < 3; s++) begin
          charLen = uart_link_pkg::len_t'(l);
          par[0] = uart_link_pkg::par_t'(p);
          par[1] = par[0];
          stopBits = uart_link_pkg::stop_t'(s);
          baudDiv = (s == 2) ? uart_link_pkg::DIV_MAX_RATE : uart_link_pkg::DIV_ONE;
          d = 8'hA5 ^ 8'(l * 16 + p * 4 + s);
          clear();
          fork
            send(0, d);
            send(1, ~d);
          join
          fork
            recv(1, d & (8'hFF >> (3 - l)));
            recv(0, ~d & (8'hFF >> (3 - l)));
          join
          step(80);
          chk(seen[0], 10'h387);
          chk(seen[1], 10'h387);
        end
    charLen = uart_link_pkg::LEN8;
    stopBits = uart_link_pkg::STOP1;
    baudDiv = uart_link_pkg::DIV_ONE;
    // Unread word holds the sender off
    send(0, 8'h3C);
    step(200);
    fork
      send(0, 8'hC3);
    join_none
    step(200);
    chk(link.devTx, 1'b1);
    chk(txR[0], 1'b0);
    recv(1, 8'h3C);
    recv(1, 8'hC3);
    // Without flow control a second word overruns the first
    flowEn = 1'b0;
    clear();
    send(0, 8'h11);
    send(0, 8'h22);
    step(200);
    recv(1, 8'h22);
    chk(seen[1][uart_link_pkg::EV_OVERRUN], 1'b1);
    // Mismatched parity is flagged at the receiver
    flowEn = 1'b1;
    par[0] = uart_link_pkg::PAR_ODD;
    par[1] = uart_link_pkg::PAR_EVEN;
    clear();
    send(0, 8'h01);
    step(200);
    chk(seen[1][uart_link_pkg::EV_PARITY], 1'b1);
    end_sim();
  end
endmodule : test_module_uart_with_flow_control
